/* File: cmps_pkg.sv */
`default_nettype none
package cmps_pkg;
    // one-hot clock modes
    typedef enum logic [6:0] {
        CMPS_MODE0 = 7'h01,
        CMPS_MODE1 = 7'h02,
        CMPS_MODE2 = 7'h04,
        CMPS_MODE3 = 7'h08,
        CMPS_MODE4 = 7'h10,
        CMPS_MODE5 = 7'h20,
        CMPS_MODE6 = 7'h40
    } cmps_mode_e;

    // mode pin encodings
    localparam logic [2:0] CMPS_PINS_MODE0 = 3'h0;
    localparam logic [2:0] CMPS_PINS_MODE1 = 3'h1;
    localparam logic [2:0] CMPS_PINS_MODE2 = 3'h2;
    localparam logic [2:0] CMPS_PINS_MODE3 = 3'h3;
    localparam logic [2:0] CMPS_PINS_MODE4 = 3'h4;
    localparam logic [2:0] CMPS_PINS_MODE5 = 3'h5;
    localparam logic [2:0] CMPS_PINS_MODE6 = 3'h6;

    // frequency setting register fields
    localparam int CMPS_PLL2_STOP_BIT = 7;
    localparam int CMPS_PLL1_STOP_BIT = 6;
    localparam int CMPS_CLOCK_IO_PIN_HIZ_BIT  = 5;
    localparam int CMPS_RSVD_BIT      = 4;
    localparam int CMPS_FR_MSB        = 3;
    localparam int CMPS_FR_LSB        = 0;

    // power-on values per mode
    localparam logic [7:0] CMPS_INIT_MODE0 = 8'h00;
    localparam logic [7:0] CMPS_INIT_MODE2 = 8'h40;
    localparam logic [7:0] CMPS_INIT_MODE3 = 8'h60;
    localparam logic [7:0] CMPS_INIT_MODE4 = 8'hA6;
    localparam logic [7:0] CMPS_INIT_MODE6 = 8'hE0;

    // divider select: log2 of the divide factor against the x4 base tick
    localparam logic [1:0] CMPS_DIV1 = 2'h0;
    localparam logic [1:0] CMPS_DIV2 = 2'h1;
    localparam logic [1:0] CMPS_DIV4 = 2'h2;

    // which internal clock a ratio is asked for
    localparam logic [1:0] CMPS_SEL_CORE   = 2'h0;
    localparam logic [1:0] CMPS_SEL_BUS    = 2'h1;
    localparam logic [1:0] CMPS_SEL_PERIPH = 2'h2;

    // frequency field codes
    localparam logic [3:0] CMPS_FR_0101 = 4'h5;
    localparam logic [3:0] CMPS_FR_0110 = 4'h6;
    localparam logic [3:0] CMPS_FR_1001 = 4'h9;
    localparam logic [3:0] CMPS_FR_1010 = 4'hA;
    localparam logic [3:0] CMPS_FR_1100 = 4'hC;
    localparam logic [3:0] CMPS_FR_1110 = 4'hE;
    localparam logic [3:0] CMPS_FR_1111 = 4'hF;
endpackage
`default_nettype wire

/* File: cmps_sync.sv */
`default_nettype none
module cmps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // two-stage synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: cmps_divider.sv */
`default_nettype none
module cmps_divider (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick_in,
    input  wire logic [1:0] div_sel,
    output var  logic       tick_out
);
    logic [1:0] count_reg;
    logic       last_reg;

    // last base tick of a divide period
    always_comb begin
        case (div_sel)
            cmps_pkg::CMPS_DIV1: last_reg = 1'b1;
            cmps_pkg::CMPS_DIV2: last_reg = count_reg[0];
            default:             last_reg = &count_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (tick_in) begin
            count_reg <= last_reg ? 2'h0 : count_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in & last_reg;
        end
    end
endmodule
`default_nettype wire

/* File: cmps_clock_mode.sv */
// Functional notes
// - mode pins decode to modes 0..6 in binary order; 7 is illegal
// - modes 0..3 take reference on crystal input; select pin low means external clock
// - modes 4..6 take reference from clock I/O pin; crystal pins unused
// - modes 4..6 use the select pin as clock pause request
// - mode 0 runs both PLLs; clock I/O drives in-phase bus clock
// - mode 1 runs both PLLs; clock I/O bus clock leads by quarter cycle
// - mode 1 drops the quarter-cycle lead when first PLL is halted
// - mode 2 runs second PLL only; clock I/O drives unaligned bus clock
// - mode 3 runs second PLL only; clock I/O stays high impedance
// - mode 4 runs first PLL only, aligned to clock I/O input
// - register starts/halts allowed PLLs; modes 0..2 also control clock I/O hiz
// - register reset only by power-on reset, kept through watchdog reset
// - power-on value: mode 0 00, mode 2 40, mode 3 60
// - power-on value: mode 4 A6, mode 6 E0
// - software sets division ratios through the register in every mode
// - core, bus and peripheral clocks each have their own divider
// - modes 4..6 read second PLL stop bit as 1
// - modes 2, 3, 6 read first PLL stop bit as 1
`default_nettype none
module cmps_clock_mode (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wdt_reset_n,
    input  wire logic       mode_select_bit2,
    input  wire logic       mode_select_bit1,
    input  wire logic       mode_select_bit0,
    input  wire logic       pause_or_crystal_select_pin,
    input  wire logic       crystal_input_pin,
    input  wire logic       clock_io_pin_in,
    input  wire logic       freq_wr_en,
    input  wire logic [7:0] freq_wr_data,
    output var  logic [7:0] freq_rd_data,
    output var  logic [2:0] clock_mode,
    output var  logic       mode_illegal,
    output var  logic       crystal_osc_en,
    output var  logic       ref_from_clock_io,
    output var  logic       pause_request,
    output var  logic       first_pll_run,
    output var  logic       second_pll_run,
    output var  logic       phase_advance,
    output var  logic       clock_io_pin_out,
    output var  logic       clock_io_pin_oe_n,
    output var  logic       core_tick,
    output var  logic       bus_tick,
    output var  logic       periph_tick
);
    logic [5:0]             pins_sync;
    logic [2:0]             md_sync;
    logic                   sel_sync;
    logic                   xin_sync;
    logic                   cio_sync;
    cmps_pkg::cmps_mode_e   mode_reg;
    cmps_pkg::cmps_mode_e   mode_next;
    logic                   illegal_next;
    logic                   sel_latch_reg;
    logic [7:0]             frequency_setting_register;
    logic [7:0]             init_next;
    logic [7:0]             wr_masked;
    logic                   ref_prev_reg;
    logic                   ref_sel;
    logic                   base_tick_reg;
    logic                   pll1_ok;
    logic                   pll2_ok;
    logic                   hiz_ok;
    logic                   clock_io_pin_in_mode;
    logic [3:0]             fr_field;
    logic                   bus_tick_int;
    logic                   bus_tick_d_reg;

    // ratio of one internal clock against the x4 base tick
    function automatic logic [1:0] ratio_sel(input logic [3:0] fr, input logic [1:0] which);
        logic [1:0] r;
        r = cmps_pkg::CMPS_DIV4;
        if (fr == cmps_pkg::CMPS_FR_1111) begin
            r = cmps_pkg::CMPS_DIV1;
        end else begin
            case (which)
                cmps_pkg::CMPS_SEL_CORE: begin
                    if (fr[3]) begin
                        r = cmps_pkg::CMPS_DIV1;
                    end else if (fr[2]) begin
                        r = cmps_pkg::CMPS_DIV2;
                    end
                end
                cmps_pkg::CMPS_SEL_BUS: begin
                    if (fr == cmps_pkg::CMPS_FR_1100 || fr == cmps_pkg::CMPS_FR_1110) begin
                        r = cmps_pkg::CMPS_DIV1;
                    end else if (fr == cmps_pkg::CMPS_FR_0101 || fr == cmps_pkg::CMPS_FR_0110 ||
                                 fr == cmps_pkg::CMPS_FR_1001 || fr == cmps_pkg::CMPS_FR_1010) begin
                        r = cmps_pkg::CMPS_DIV2;
                    end
                end
                default: begin
                    if (fr == cmps_pkg::CMPS_FR_0110 || fr == cmps_pkg::CMPS_FR_1010 ||
                        fr == cmps_pkg::CMPS_FR_1110) begin
                        r = cmps_pkg::CMPS_DIV2;
                    end
                end
            endcase
        end
        return r;
    endfunction

    // pin synchronisers
    cmps_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .clk      (clk),
        // straps must pass while reset is held
        .rst_n    (1'b1),
        .async_in ({mode_select_bit2, mode_select_bit1, mode_select_bit0,
                    pause_or_crystal_select_pin, crystal_input_pin, clock_io_pin_in}),
        .sync_out (pins_sync)
    );

    assign md_sync  = pins_sync[5:3];
    assign sel_sync = pins_sync[2];
    assign xin_sync = pins_sync[1];
    assign cio_sync = pins_sync[0];

    always_comb begin
        illegal_next = 1'b0;
        case (md_sync)
            cmps_pkg::CMPS_PINS_MODE0: mode_next = cmps_pkg::CMPS_MODE0;
            cmps_pkg::CMPS_PINS_MODE1: mode_next = cmps_pkg::CMPS_MODE1;
            cmps_pkg::CMPS_PINS_MODE2: mode_next = cmps_pkg::CMPS_MODE2;
            cmps_pkg::CMPS_PINS_MODE3: mode_next = cmps_pkg::CMPS_MODE3;
            cmps_pkg::CMPS_PINS_MODE4: mode_next = cmps_pkg::CMPS_MODE4;
            cmps_pkg::CMPS_PINS_MODE5: mode_next = cmps_pkg::CMPS_MODE5;
            cmps_pkg::CMPS_PINS_MODE6: mode_next = cmps_pkg::CMPS_MODE6;
            default: begin
                mode_next    = cmps_pkg::CMPS_MODE0;
                illegal_next = 1'b1;
            end
        endcase
    end

    always_comb begin
        case (mode_next)
            cmps_pkg::CMPS_MODE0: init_next = cmps_pkg::CMPS_INIT_MODE0;
            cmps_pkg::CMPS_MODE1: init_next = cmps_pkg::CMPS_INIT_MODE0;
            cmps_pkg::CMPS_MODE2: init_next = cmps_pkg::CMPS_INIT_MODE2;
            cmps_pkg::CMPS_MODE3: init_next = cmps_pkg::CMPS_INIT_MODE3;
            cmps_pkg::CMPS_MODE4: init_next = cmps_pkg::CMPS_INIT_MODE4;
            cmps_pkg::CMPS_MODE5: init_next = cmps_pkg::CMPS_INIT_MODE4;
            cmps_pkg::CMPS_MODE6: init_next = cmps_pkg::CMPS_INIT_MODE6;
            default:              init_next = cmps_pkg::CMPS_INIT_MODE0;
        endcase
    end

    // capture straps while power-on reset is held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg      <= mode_next;
            mode_illegal  <= illegal_next;
            sel_latch_reg <= sel_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clock_mode <= md_sync;
        end
    end

    // per-mode permissions
    always_comb begin
        pll1_ok      = 1'b0;
        pll2_ok      = 1'b0;
        hiz_ok       = 1'b0;
        clock_io_pin_in_mode = 1'b0;
        case (mode_reg)
            cmps_pkg::CMPS_MODE0, cmps_pkg::CMPS_MODE1: begin
                pll1_ok = 1'b1;
                pll2_ok = 1'b1;
                hiz_ok  = 1'b1;
            end
            cmps_pkg::CMPS_MODE2: begin
                pll2_ok = 1'b1;
                hiz_ok  = 1'b1;
            end
            cmps_pkg::CMPS_MODE3: begin
                pll2_ok = 1'b1;
            end
            cmps_pkg::CMPS_MODE4, cmps_pkg::CMPS_MODE5: begin
                pll1_ok      = 1'b1;
                clock_io_pin_in_mode = 1'b1;
            end
            default: begin
                clock_io_pin_in_mode = 1'b1;
            end
        endcase
    end

    always_comb begin
        wr_masked = frequency_setting_register;
        wr_masked[cmps_pkg::CMPS_FR_MSB:cmps_pkg::CMPS_FR_LSB] =
            freq_wr_data[cmps_pkg::CMPS_FR_MSB:cmps_pkg::CMPS_FR_LSB];
        wr_masked[cmps_pkg::CMPS_RSVD_BIT] = 1'b0;
        if (pll2_ok) begin
            wr_masked[cmps_pkg::CMPS_PLL2_STOP_BIT] = freq_wr_data[cmps_pkg::CMPS_PLL2_STOP_BIT];
        end
        if (pll1_ok) begin
            wr_masked[cmps_pkg::CMPS_PLL1_STOP_BIT] = freq_wr_data[cmps_pkg::CMPS_PLL1_STOP_BIT];
        end
        if (hiz_ok) begin
            wr_masked[cmps_pkg::CMPS_CLOCK_IO_PIN_HIZ_BIT] = freq_wr_data[cmps_pkg::CMPS_CLOCK_IO_PIN_HIZ_BIT];
        end
    end

    // only power-on reset loads it; watchdog reset does not
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frequency_setting_register <= init_next;
        end else if (freq_wr_en) begin
            frequency_setting_register <= wr_masked;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            freq_rd_data <= 8'h00;
        end else begin
            freq_rd_data <= frequency_setting_register;
            freq_rd_data[cmps_pkg::CMPS_RSVD_BIT] <= 1'b0;
            if (!pll2_ok) begin
                freq_rd_data[cmps_pkg::CMPS_PLL2_STOP_BIT] <= 1'b1;
            end
            if (!pll1_ok) begin
                freq_rd_data[cmps_pkg::CMPS_PLL1_STOP_BIT] <= 1'b1;
            end
            if (clock_io_pin_in_mode) begin
                freq_rd_data[cmps_pkg::CMPS_CLOCK_IO_PIN_HIZ_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_pll_run  <= 1'b0;
            second_pll_run <= 1'b0;
        end else begin
            first_pll_run  <= pll1_ok & ~frequency_setting_register[cmps_pkg::CMPS_PLL1_STOP_BIT];
            second_pll_run <= pll2_ok & ~frequency_setting_register[cmps_pkg::CMPS_PLL2_STOP_BIT];
        end
    end

    // reference source and select pin role
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            crystal_osc_en    <= 1'b0;
            ref_from_clock_io <= 1'b0;
            pause_request     <= 1'b0;
        end else begin
            crystal_osc_en    <= ~clock_io_pin_in_mode & sel_latch_reg;
            ref_from_clock_io <= clock_io_pin_in_mode;
            pause_request     <= clock_io_pin_in_mode & sel_sync;
        end
    end

    assign ref_sel = clock_io_pin_in_mode ? cio_sync : xin_sync;

    always_ff @(posedge clk) begin
        if (!rst_n || !wdt_reset_n) begin
            ref_prev_reg  <= 1'b0;
            base_tick_reg <= 1'b0;
        end else begin
            ref_prev_reg  <= ref_sel;
            base_tick_reg <= ref_sel & ~ref_prev_reg;
        end
    end

    assign fr_field = frequency_setting_register[cmps_pkg::CMPS_FR_MSB:cmps_pkg::CMPS_FR_LSB];

    cmps_divider u_core_div (
        .clk      (clk),
        .rst_n    (rst_n & wdt_reset_n),
        .tick_in  (base_tick_reg),
        .div_sel  (ratio_sel(fr_field, cmps_pkg::CMPS_SEL_CORE)),
        .tick_out (core_tick)
    );

    cmps_divider u_bus_div (
        .clk      (clk),
        .rst_n    (rst_n & wdt_reset_n),
        .tick_in  (base_tick_reg),
        .div_sel  (ratio_sel(fr_field, cmps_pkg::CMPS_SEL_BUS)),
        .tick_out (bus_tick_int)
    );

    cmps_divider u_periph_div (
        .clk      (clk),
        .rst_n    (rst_n & wdt_reset_n),
        .tick_in  (base_tick_reg),
        .div_sel  (ratio_sel(fr_field, cmps_pkg::CMPS_SEL_PERIPH)),
        .tick_out (periph_tick)
    );

    // bus tick registered one cycle; in mode 1 with first PLL running the pin toggles with it, otherwise one cycle after it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_tick_d_reg <= 1'b0;
            bus_tick       <= 1'b0;
        end else begin
            bus_tick_d_reg <= bus_tick_int;
            bus_tick       <= bus_tick_int;
        end
    end

    // lead only in mode 1 with first PLL running
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_advance <= 1'b0;
        end else begin
            phase_advance <= (mode_reg == cmps_pkg::CMPS_MODE1) &
                             ~frequency_setting_register[cmps_pkg::CMPS_PLL1_STOP_BIT];
        end
    end

    // clock I/O output toggles on bus clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clock_io_pin_out <= 1'b0;
        end else if (phase_advance ? bus_tick_int : bus_tick_d_reg) begin
            clock_io_pin_out <= ~clock_io_pin_out;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clock_io_pin_oe_n <= 1'b1;
        end else begin
            clock_io_pin_oe_n <= ~hiz_ok | frequency_setting_register[cmps_pkg::CMPS_CLOCK_IO_PIN_HIZ_BIT];
        end
    end
endmodule
`default_nettype wire

/* File: cmps_ref_src.sv */
`default_nettype none
module cmps_ref_src (
    output var logic ref_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ref_clk = 1'b0;
    task automatic burst(input int n, input int half_ns);
        repeat (n) begin
            ref_clk = 1'b1;
            #(half_ns);
            ref_clk = 1'b0;
            #(half_ns);
        end
    endtask
endmodule
`default_nettype wire

/* File: cmps_clock_mode_sva.sv */
`default_nettype none
module cmps_clock_mode_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       wdt_reset_n,
    input wire logic       pause_or_crystal_select_pin,
    input wire logic       freq_wr_en,
    input wire logic [7:0] freq_rd_data,
    input wire logic [2:0] clock_mode,
    input wire logic       ref_from_clock_io,
    input wire logic       pause_request,
    input wire logic       first_pll_run,
    input wire logic       second_pll_run,
    input wire logic       phase_advance,
    input wire logic       clock_io_pin_out,
    input wire logic       clock_io_pin_oe_n,
    input wire logic       bus_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic live_reg;
    logic live2_reg;
    logic io_mode;
    always_ff @(posedge clk) begin
        live_reg  <= rst_n;
        live2_reg <= rst_n & live_reg;
    end
    assign io_mode = (clock_mode == 3'h4) || (clock_mode == 3'h5) || (clock_mode == 3'h6);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ref_sel;
        live_reg |-> ref_from_clock_io == io_mode;
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("reference source wrong");
    property p_hiz;
        live_reg && clock_mode != 3'h7 |-> clock_io_pin_oe_n == (clock_mode < 3'h3 ? freq_rd_data[5] : 1'b1);
    endproperty
    a_hiz: assert property (p_hiz) else $error("clock pin drive wrong");
    property p_pll1;
        live_reg |-> first_pll_run == !freq_rd_data[6];
    endproperty
    a_pll1: assert property (p_pll1) else $error("first pll run wrong");
    property p_pll2;
        live_reg |-> second_pll_run == !freq_rd_data[7];
    endproperty
    a_pll2: assert property (p_pll2) else $error("second pll run wrong");
    property p_stop_forced;
        live_reg |-> (!io_mode || freq_rd_data[7]) && (!(clock_mode inside {3'h2, 3'h3, 3'h6}) || freq_rd_data[6]);
    endproperty
    a_stop_forced: assert property (p_stop_forced) else $error("stop bit not forced");
    property p_advance;
        live_reg |-> phase_advance == (clock_mode == 3'h1 && !freq_rd_data[6]);
    endproperty
    a_advance: assert property (p_advance) else $error("phase advance wrong");
    property p_pause;
        (io_mode && pause_or_crystal_select_pin)[*5] |-> pause_request;
    endproperty
    a_pause: assert property (p_pause) else $error("pause request missed");
    property p_mode_hold;
        live2_reg |-> $stable(clock_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("clock mode changed");
    property p_wdt_keep;
        !wdt_reset_n && !freq_wr_en && !$past(freq_wr_en) |=> $stable(freq_rd_data);
    endproperty
    a_wdt_keep: assert property (p_wdt_keep) else $error("register lost on watchdog");
    property p_clkio;
        live2_reg && wdt_reset_n && bus_tick && clock_mode == 3'h0 && !clock_io_pin_oe_n |=> $changed(clock_io_pin_out);
    endproperty
    a_clkio: assert property (p_clkio) else $error("clock pin not toggled");
    property p_lead;
        live2_reg && bus_tick && phase_advance |-> $changed(clock_io_pin_out);
    endproperty
    a_lead: assert property (p_lead) else $error("clock pin lead missing");
endmodule
bind cmps_clock_mode cmps_clock_mode_chk cmps_clock_mode_chk_i (
    .clk(clk), .rst_n(rst_n), .wdt_reset_n(wdt_reset_n), .freq_wr_en(freq_wr_en),
    .pause_or_crystal_select_pin(pause_or_crystal_select_pin), .freq_rd_data(freq_rd_data),
    .clock_mode(clock_mode), .ref_from_clock_io(ref_from_clock_io), .pause_request(pause_request),
    .first_pll_run(first_pll_run), .second_pll_run(second_pll_run), .phase_advance(phase_advance),
    .clock_io_pin_out(clock_io_pin_out), .clock_io_pin_oe_n(clock_io_pin_oe_n), .bus_tick(bus_tick)
);
`default_nettype wire

/* File: cmps_clock_mode_tb_top.sv */
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end
module cmps_clock_mode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] INIT_TAB [0:6] = '{8'h00, 8'h00, 8'h40, 8'h60, 8'hA6, 8'hA6, 8'hE0};
    logic       clk = 1'b0, rst_n = 1'b0, wdt_reset_n = 1'b1, sel = 1'b1, freq_wr_en = 1'b0;
    logic [2:0] md = 3'h0;
    logic [7:0] freq_wr_data = 8'h00;
    logic [7:0] freq_rd_data;
    logic [2:0] clock_mode;
    logic       crystal_output_pin_in, ext_io, clock_io_pin_in, mode_illegal, crystal_osc_en, ref_from_clock_io;
    logic       pause_request, first_pll_run, second_pll_run, phase_advance, clock_io_pin_out;
    logic       clock_io_pin_oe_n, core_tick, bus_tick, periph_tick;
    int         n_mismatch = 0, cmp_count = 0, cyc = 0, n_core = 0, n_bus = 0, n_per = 0;
    // clock pin wire: device drives only with enable low
    assign clock_io_pin_in = clock_io_pin_oe_n ? ext_io : clock_io_pin_out;
    cmps_ref_src crystal_output_pin_src_i (.ref_clk(crystal_output_pin_in));
    cmps_ref_src io_src_i (.ref_clk(ext_io));
    cmps_clock_mode cmps_clock_mode_i (
        .clk(clk), .rst_n(rst_n), .wdt_reset_n(wdt_reset_n), .mode_select_bit2(md[2]),
        .mode_select_bit1(md[1]), .mode_select_bit0(md[0]), .pause_or_crystal_select_pin(sel),
        .crystal_input_pin(crystal_output_pin_in), .clock_io_pin_in(clock_io_pin_in), .freq_wr_en(freq_wr_en),
        .freq_wr_data(freq_wr_data), .freq_rd_data(freq_rd_data), .clock_mode(clock_mode),
        .mode_illegal(mode_illegal), .crystal_osc_en(crystal_osc_en), .ref_from_clock_io(ref_from_clock_io),
        .pause_request(pause_request), .first_pll_run(first_pll_run), .second_pll_run(second_pll_run),
        .phase_advance(phase_advance), .clock_io_pin_out(clock_io_pin_out),
        .clock_io_pin_oe_n(clock_io_pin_oe_n), .core_tick(core_tick), .bus_tick(bus_tick),
        .periph_tick(periph_tick)
    );
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        n_core += int'(core_tick);
        n_bus += int'(bus_tick);
        n_per += int'(periph_tick);
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic por(input logic [2:0] m, input logic s);
        @(negedge clk);
        // straps applied together with reset assertion
        md = m;
        sel = s;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        freq_wr_en = 1'b1;
        freq_wr_data = d;
        @(negedge clk);
        freq_wr_en = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pulses(input bit io, input int n, input int half);
        @(negedge clk);
        n_core = 0;
        n_bus = 0;
        n_per = 0;
        if (io)
            io_src_i.burst(n, half);
        else
            crystal_output_pin_src_i.burst(n, half);
        repeat (8) @(negedge clk);
    endtask
    task automatic test_modes();
        for (int m = 0; m < 7; m++) begin
            por(3'(m), 1'b1);
            `CHK("mode", 3'(m), clock_mode)
            `CHK("init", INIT_TAB[m], freq_rd_data)
            `CHK("ref io", m >= 4, ref_from_clock_io)
            `CHK("crystal_output_pin", m < 4, crystal_osc_en)
            `CHK("pll1", !INIT_TAB[m][6], first_pll_run)
            `CHK("pll2", !INIT_TAB[m][7], second_pll_run)
            `CHK("oe_n", m >= 3, clock_io_pin_oe_n)
            `CHK("adv", m == 1, phase_advance)
            `CHK("illegal", 1'b0, mode_illegal)
        end
        por(3'h7, 1'b1);
        `CHK("illegal7", 1'b1, mode_illegal)
        $display("test_modes done");
    endtask
    task automatic test_pins();
        por(3'h0, 1'b0);
        `CHK("crystal_output_pin sel", 1'b0, crystal_osc_en)
        sel = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("pause0", 1'b0, pause_request)
        por(3'h4, 1'b0);
        sel = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("pause4", 1'b1, pause_request)
        $display("test_pins done");
    endtask
    task automatic test_reg();
        por(3'h2, 1'b1);
        wr(8'hFF);
        `CHK("rd2", 8'hEF, freq_rd_data)
        `CHK("oe2", 1'b1, clock_io_pin_oe_n)
        wr(8'h05);
        `CHK("rd2b", 8'h45, freq_rd_data)
        `CHK("pll2 on", 1'b1, second_pll_run)
        por(3'h4, 1'b1);
        wr(8'h00);
        `CHK("rd4", 8'hA0, freq_rd_data)
        `CHK("pll1 on", 1'b1, first_pll_run)
        por(3'h6, 1'b1);
        wr(8'h00);
        `CHK("rd6", 8'hE0, freq_rd_data)
        por(3'h1, 1'b1);
        wr(8'h40);
        `CHK("adv off", 1'b0, phase_advance)
        wr(8'h00);
        `CHK("adv on", 1'b1, phase_advance)
        $display("test_reg done");
    endtask
    task automatic test_ticks();
        por(3'h0, 1'b1);
        wr(8'hC8);
        `CHK("rd0", 8'hC8, freq_rd_data)
        pulses(1'b0, 16, 10);
        `CHK("core", 16, n_core)
        `CHK("bus", 4, n_bus)
        `CHK("per", 4, n_per)
        wr(8'hCF);
        pulses(1'b0, 8, 35);
        `CHK("bus div1", 8, n_bus)
        por(3'h4, 1'b1);
        wr(8'hCF);
        `CHK("rd4f", 8'hEF, freq_rd_data)
        pulses(1'b1, 8, 10);
        `CHK("io core", 8, n_core)
        pulses(1'b1, 0, 10);
        `CHK("stopped", 0, n_bus)
        wdt_reset_n = 1'b0;
        pulses(1'b1, 4, 10);
        `CHK("wdt ticks", 0, n_bus)
        `CHK("wdt reg", 8'hEF, freq_rd_data)
        wdt_reset_n = 1'b1;
        pulses(1'b1, 4, 10);
        `CHK("after wdt", 4, n_per)
        por(3'h1, 1'b1);
        pulses(1'b0, 4, 10);
        `CHK("bus mode1", 1, n_bus)
        `CHK("pin mode1", 1'b1, clock_io_pin_out)
        $display("test_ticks done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        test_modes();
        test_pins();
        test_reg();
        test_ticks();
        complete_run();
    end
endmodule
`default_nettype wire
